// ===== design/sp_pkg.sv
// Purpose: Shared constants for the three-wire serial port
// Assumes: 8-bit register port, byte addresses
// Notes:   Field positions are bit indices within 8-bit registers
package sp_pkg;
    localparam logic [15:0] MODE_CTRL_0_ADDR = 16'hff80;
    localparam logic [15:0] MODE_CTRL_1_ADDR = 16'hff88;
    localparam logic [15:0] CLOCK_SEL_OFF    = 16'h0001;
    localparam logic [15:0] TX_BUF_OFF       = 16'h0002;
    localparam logic [15:0] SHIFT_REG_OFF    = 16'h0003;
    localparam int          ENABLE_BIT       = 7;
    localparam int          TRMD_BIT         = 6;
    localparam int          SSEL_BIT         = 5;
    localparam int          DIR_BIT          = 4;
    localparam int          BUSY_BIT         = 0;
    localparam int          CKP_BIT          = 4;
    localparam int          DAP_BIT          = 3;
    localparam logic [2:0]  RATE_EXTERNAL    = 3'h7;
    localparam logic [7:0]  MODE_WR_MASK_0   = 8'hd0;
    localparam logic [7:0]  MODE_WR_MASK_1   = 8'hf0;
    localparam logic [7:0]  CLOCK_SEL_MASK   = 8'h1f;
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [4:0]  LAST_EDGE        = 5'h0f;
    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_RUN  = 1'b1
    } xfer_phase_t;
endpackage

// ===== design/sio_edge_if.sv
// Purpose: Edge pulses and synced pin levels inside the port
// Assumes: One clock domain
// Notes:   Driven by the timer, read by shifter and top
`timescale 1ns/1ps
`default_nettype none
interface sio_edge_if;
    logic lead;
    logic trail;
    logic si_level;
    logic ssi_level;
    modport source (output lead, output trail,
                    output si_level, output ssi_level);
    modport sink (input lead, input trail,
                  input si_level, input ssi_level);
endinterface
`default_nettype wire

// ===== design/sck_timer.sv
// Purpose: Serial clock divider, pin synchronisers, edge finder
// Assumes: External serial clock far slower than clock
// Notes:   Lead is the edge away from the idle level
`timescale 1ns/1ps
`default_nettype none
module sck_timer (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       external,
    input  wire logic       idle_level,
    input  wire logic [2:0] rate,
    input  wire logic       sck_pin,
    input  wire logic       si_pin,
    input  wire logic       ssi_pin,
    sio_edge_if.source      edges
);
    typedef struct packed {
        logic [1:0] sck_s;
        logic [1:0] si_s;
        logic [1:0] ssi_s;
        logic       prev;
        logic       away;
        logic [6:0] cnt;
        logic       lead;
        logic       trail;
    } gen_t;
    gen_t s;
    gen_t next_s;

    // Half period of 2**rate cycles
    function automatic logic [6:0] half_limit(input logic [2:0] r);
        half_limit = 7'((7'h01 << r) - 7'h01);
    endfunction

    always_comb begin
        next_s = s;
        next_s.lead = 1'b0;
        next_s.trail = 1'b0;
        next_s.sck_s = {s.sck_s[0], sck_pin};
        next_s.si_s = {s.si_s[0], si_pin};
        next_s.ssi_s = {s.ssi_s[0], ssi_pin};
        if (!run || external) begin
            next_s.cnt = 7'h00;
            next_s.away = 1'b0;
            next_s.prev = s.sck_s[1] ^ idle_level;
            if (run) begin
                next_s.lead = next_s.prev & ~s.prev;
                next_s.trail = ~next_s.prev & s.prev;
            end
        end else if (s.cnt == half_limit(rate)) begin
            next_s.cnt = 7'h00;
            next_s.away = ~s.away;
            next_s.lead = ~s.away;
            next_s.trail = s.away;
        end else begin
            next_s.cnt = 7'(s.cnt + 7'h01);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign edges.lead = s.lead;
    assign edges.trail = s.trail;
    assign edges.si_level = s.si_s[1];
    assign edges.ssi_level = s.ssi_s[1];
endmodule
`default_nettype wire

// ===== design/word_shifter.sv
// Purpose: 8-bit shift register with selectable bit order
// Assumes: Edge pulses one cycle long
// Notes:   Sample and change edges swap with the phase bit
`timescale 1ns/1ps
`default_nettype none
module word_shifter (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [7:0] load_data,
    input  wire logic       active,
    input  wire logic       dap,
    input  wire logic       lsb_first,
    sio_edge_if.sink        edges,
    output var  logic [7:0] data,
    output var  logic       out_bit
);
    typedef struct packed {
        logic [7:0] data;
        logic       out_bit;
    } shf_t;
    shf_t s;
    shf_t next_s;

    function automatic logic pick(input logic [7:0] d, input logic lsb);
        pick = lsb ? d[0] : d[7];
    endfunction

    always_comb begin
        next_s = s;
        if (clear) begin
            next_s = '0;
        end else if (load) begin
            next_s.data = load_data;
            next_s.out_bit = pick(load_data, lsb_first);
        end else if (active) begin
            if (dap ? edges.lead : edges.trail) begin
                next_s.data = lsb_first ? {edges.si_level, s.data[7:1]}
                                        : {s.data[6:0], edges.si_level};
            end
            if (dap ? edges.trail : edges.lead) begin
                next_s.out_bit = pick(s.data, lsb_first);
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign data = s.data;
    assign out_bit = s.out_bit;
endmodule
`default_nettype wire

// ===== design/three_wire_serial_port.sv
// Purpose: One channel of a clocked three-wire serial port
// Assumes: Register port with one-cycle strobes, read data next cycle
// Notes:   SLAVE_SELECT_PRESENT picks the channel with slave select
`timescale 1ns/1ps
`default_nettype none
module three_wire_serial_port #(
    parameter logic        SLAVE_SELECT_PRESENT = 1'b0,
    parameter logic [15:0] MODE_ADDR            = sp_pkg::MODE_CTRL_0_ADDR
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output var  logic [7:0]  rd_data,
    input  wire logic        serial_clock_in,
    output var  logic        serial_clock_out,
    output var  logic        serial_clock_oe,
    input  wire logic        serial_input,
    output var  logic        serial_output,
    output var  logic        serial_output_oe,
    input  wire logic        slave_select_n
);
    localparam logic [7:0] MODE_MASK = SLAVE_SELECT_PRESENT
        ? sp_pkg::MODE_WR_MASK_1 : sp_pkg::MODE_WR_MASK_0;

    typedef struct packed {
        logic [7:0]          mode;
        logic [7:0]          csel;
        logic [7:0]          txb;
        sp_pkg::xfer_phase_t phase;
        logic [4:0]          ecnt;
        logic                sck;
        logic                sck_oe;
        logic                so;
        logic                so_oe;
        logic [7:0]          rdat;
    } ctl_t;
    ctl_t s;
    ctl_t next_s;

    function automatic logic [15:0] reg_addr(input logic [15:0] off);
        reg_addr = 16'(MODE_ADDR + off);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Decode and derived controls

    logic       hit_mode;
    logic       hit_csel;
    logic       hit_txb;
    logic       hit_sio;
    logic       enable;
    logic       trmd;
    logic       busy;
    logic       external;
    logic       idle_level;
    logic       dap;
    logic       ss_block;
    logic       tx_start;
    logic       rx_start;
    logic       edge_pulse;
    logic       kill;
    logic [7:0] sio_data;
    logic       sio_bit;

    sio_edge_if edges ();

    assign hit_mode = (addr == MODE_ADDR);
    assign hit_csel = (addr == reg_addr(sp_pkg::CLOCK_SEL_OFF));
    assign hit_txb = (addr == reg_addr(sp_pkg::TX_BUF_OFF));
    assign hit_sio = (addr == reg_addr(sp_pkg::SHIFT_REG_OFF));

    assign enable = s.mode[sp_pkg::ENABLE_BIT];
    assign trmd = s.mode[sp_pkg::TRMD_BIT];
    assign busy = (s.phase == sp_pkg::PH_RUN);
    assign external = (s.csel[2:0] == sp_pkg::RATE_EXTERNAL);
    assign idle_level = ~s.csel[sp_pkg::CKP_BIT];
    assign dap = s.csel[sp_pkg::DAP_BIT];

    // Select pin only when chosen
    // Select is only honoured in slave mode; a master ignores it
    assign ss_block = SLAVE_SELECT_PRESENT
                   && s.mode[sp_pkg::SSEL_BIT]
                   && external
                   && edges.ssi_level;

    assign tx_start = wr_en && hit_txb && enable && trmd
                   && !busy && !ss_block;

    assign rx_start = rd_en && hit_sio && enable && !trmd
                   && !busy && !ss_block;

    assign edge_pulse = busy && !ss_block
                     && (edges.lead || edges.trail);

    ////////////////////////////////////////////////////////////////////
    // Serial clock timing and shifting

    sck_timer timer (
        .clock      (clock),
        .rst_n      (rst_n),
        .run        (busy),
        .external   (external),
        .idle_level (idle_level),
        .rate       (s.csel[2:0]),
        .sck_pin    (serial_clock_in),
        .si_pin     (serial_input),
        .ssi_pin    (slave_select_n),
        .edges      (edges.source)
    );

    word_shifter shifter (
        .clock     (clock),
        .rst_n     (rst_n),
        .clear     (kill),
        .load      (tx_start),
        .load_data (wr_data),
        .active    (busy && !ss_block),
        .dap       (dap),
        .lsb_first (s.mode[sp_pkg::DIR_BIT]),
        .edges     (edges.sink),
        .data      (sio_data),
        .out_bit   (sio_bit)
    );

    ////////////////////////////////////////////////////////////////////
    // Registers and transfer control

    always_comb begin
        next_s = s;
        kill = 1'b0;

        if (wr_en && hit_mode) begin
            next_s.mode = wr_data & MODE_MASK;
        end
        if (wr_en && hit_csel) begin
            next_s.csel = wr_data & sp_pkg::CLOCK_SEL_MASK;
        end
        if (wr_en && hit_txb && !busy) begin
            next_s.txb = wr_data;
        end

        // Disable clears the logic
        // Acts on the edge that stores the cleared bit, not later
        if (!next_s.mode[sp_pkg::ENABLE_BIT]) begin
            kill = 1'b1;
            next_s.phase = sp_pkg::PH_IDLE;
            next_s.ecnt = 5'h00;
        end else if (tx_start || rx_start) begin
            next_s.phase = sp_pkg::PH_RUN;
            next_s.ecnt = 5'h00;
        end else if (edge_pulse) begin
            next_s.ecnt = 5'(s.ecnt + 5'h01);
            if (s.ecnt == sp_pkg::LAST_EDGE) begin
                next_s.phase = sp_pkg::PH_IDLE;
            end
        end

        if (!enable || external || !busy) begin
            next_s.sck = idle_level;
        end else if (edges.lead) begin
            next_s.sck = ~idle_level;
        end else if (edges.trail) begin
            next_s.sck = idle_level;
        end
        next_s.sck_oe = enable && !external;

        // Shift data to the output pin
        next_s.so = enable && trmd && sio_bit;
        next_s.so_oe = enable && !ss_block;

        // Read data stands one cycle only
        next_s.rdat = sp_pkg::REG_RESET;
        if (rd_en) begin
            if (hit_mode) begin
                next_s.rdat = {s.mode[7:1], busy};
            end else if (hit_csel) begin
                next_s.rdat = s.csel;
            end else if (hit_txb) begin
                next_s.rdat = s.txb;
            end else if (hit_sio) begin
                next_s.rdat = sio_data;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sck <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rdat;
    assign serial_clock_out = s.sck;
    assign serial_clock_oe = s.sck_oe;
    assign serial_output = s.so;
    assign serial_output_oe = s.so_oe;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence word_end_s;
        busy && edge_pulse && (s.ecnt == sp_pkg::LAST_EDGE);
    endsequence

    sequence disabled_s;
        !enable;
    endsequence

    tx_start_a: assert property (tx_start |=> busy)
        else $error("Transmit start did not set busy");

    tx_load_a: assert property (tx_start |=> sio_data == $past(wr_data))
        else $error("Written word not in shift register");

    buf_store_a: assert property (
        wr_en && hit_txb && !busy |=> s.txb == $past(wr_data))
        else $error("Transmit buffer did not store write");

    rx_start_a: assert property (
        rd_en && hit_sio && enable && !trmd && !busy && !ss_block
        && !(wr_en) |=> busy)
        else $error("Shift register read did not start receive");

    ss_block_a: assert property (
        !busy && ss_block && wr_en && hit_txb |=> !busy)
        else $error("Transfer started while deselected");

    disable_clr_a: assert property (disabled_s |=> !busy && sio_data == 8'h00)
        else $error("Disable did not clear the logic");

    rx_out_low_a: assert property (!trmd |=> !serial_output)
        else $error("Output not low in receive-only mode");

    busy_read_a: assert property (
        rd_en && hit_mode |=> rd_data[sp_pkg::BUSY_BIT] == $past(busy))
        else $error("Status flag does not match busy");

    word_end_a: assert property (
        word_end_s ##0 enable |=> !busy)
        else $error("Busy did not clear after last bit");

    stop_clock_a: assert property (disabled_s |=> !serial_clock_oe)
        else $error("Serial clock driven while stopped");

    sio_read_a: assert property (
        rd_en && hit_sio |=> rd_data == $past(sio_data))
        else $error("Shift register readback wrong");
endmodule
`default_nettype wire

// ===== tb/serial_peer.sv
// Purpose: Peripheral chip on the far side of the serial port
// Assumes: Clock idles high, data changes on fall, sampled on rise
// Notes:   Drives the line clock only while it is the master
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input  wire logic       line_sck,
    input  wire logic       line_so,
    output var  logic       peer_sck,
    output var  logic       peer_si,
    output var  logic [7:0] got
);
    logic [7:0] send;
    logic       lsb;
    initial begin
        peer_sck = 1'b1;
        peer_si  = 1'b0;
        got      = 8'h00;
        send     = 8'h00;
        lsb      = 1'b0;
    end
    task automatic load(input logic [7:0] word, input logic order);
        send = word;
        lsb  = order;
        got  = 8'h00;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // shift out on fall
    // Spent bits come back inverted so a stale line never looks valid
    always @(negedge line_sck) begin
        peer_si <= lsb ? send[0] : send[7];
        send    <= lsb ? {~send[0], send[7:1]} : {send[6:0], ~send[7]};
    end
    always @(posedge line_sck) begin
        got <= lsb ? {line_so, got[7:1]} : {got[6:0], line_so};
    end
    // eight clocks per word
    // Clock stands still outside the frame
    task automatic frame();
        repeat (8) begin
            #100 peer_sck = 1'b0;
            #100 peer_sck = 1'b1;
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/three_wire_serial_port_test.sv
// Purpose: Self-checking bench for the serial port, select channel
// Assumes: Rate 2 as master, 200 ns link clock as slave
// Notes:   Every wait is bounded
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected at %0t: %h vs %h", $time, (g), (e)); end end
module three_wire_serial_port_test;
    localparam logic [15:0] B = sp_pkg::MODE_CTRL_1_ADDR;
    logic        clock;
    logic        rst_n;
    logic [15:0] addr;
    logic [7:0]  wr_data;
    logic        wr_en;
    logic        rd_en;
    logic [7:0]  rd_data;
    logic        sck_out;
    logic        sck_oe;
    logic        so;
    logic        so_oe;
    logic        ssn;
    logic        peer_sck;
    logic        peer_si;
    logic [7:0]  got;
    logic        so_hold;
    logic [7:0]  d;
    wire logic   line_sck;
    wire logic   line_so;
    int          err_total = 0;
    int          compares = 0;
    assign line_sck = sck_oe ? sck_out : peer_sck;
    assign line_so  = so_oe ? so : so_hold;
    // Released data line shows the inverse of its last value
    always @(posedge clock) if (so_oe) so_hold <= ~so;
    always #12.5 clock = ~clock;
    three_wire_serial_port #(
        .SLAVE_SELECT_PRESENT(1'b1),
        .MODE_ADDR           (B)
    ) dut (
        .clock           (clock),
        .rst_n           (rst_n),
        .addr            (addr),
        .wr_data         (wr_data),
        .wr_en           (wr_en),
        .rd_en           (rd_en),
        .rd_data         (rd_data),
        .serial_clock_in (line_sck),
        .serial_clock_out(sck_out),
        .serial_clock_oe (sck_oe),
        .serial_input    (peer_si),
        .serial_output   (so),
        .serial_output_oe(so_oe),
        .slave_select_n  (ssn)
    );
    serial_peer peer (
        .line_sck(line_sck),
        .line_so (line_so),
        .peer_sck(peer_sck),
        .peer_si (peer_si),
        .got     (got)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compares %0d, err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clock);
        wr_en   <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 v = rd_data;
    endtask
    // no access or mode change until idle
    task automatic wait_idle();
        logic [7:0] v;
        for (int i = 0; i < 300; i++) begin
            rd(B, v);
            if (v[0] === 1'b0) return;
        end
        `CHK(v, 8'h00)
        end_sim();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int i = 0; i < 5; i++) begin
            rd(B + 16'(i), d);
            `CHK(d, 8'h00)
        end
        `CHK(sck_out, 1'b1)
        `CHK(so_oe, 1'b0)
    endtask
    task automatic t_master(input logic [7:0] w, input logic [7:0] pw,
                            input logic lsb);
        logic [7:0] m;
        // bit 5 kept clear unless select is wanted
        m = lsb ? 8'hd0 : 8'hc0;
        wr(B + 16'h0001, 8'h02);
        wr(B, m);
        peer.load(pw, lsb);
        wr(B + 16'h0002, w);
        rd(B, d);
        `CHK(d, m | 8'h01)
        `CHK(sck_oe, 1'b1)
        wait_idle();
        `CHK(got, w)
        rd(B + 16'h0003, d);
        `CHK(d, pw)
        wr(B + 16'h0003, ~pw);
        rd(B + 16'h0003, d);
        `CHK(d, pw)
        rd(B + 16'h0002, d);
        `CHK(d, w)
        // mode back to default frees the pins
        wr(B, 8'h00);
    endtask
    task automatic t_disable();
        wr(B, 8'hc0);
        peer.load(8'h00, 1'b0);
        wr(B + 16'h0002, 8'h81);
        repeat (10) @(posedge clock);
        wr(B, 8'h40);
        rd(B, d);
        `CHK(d, 8'h40)
        rd(B + 16'h0003, d);
        `CHK(d, 8'h00)
        `CHK(so, 1'b0)
    endtask
    task automatic t_receive();
        wr(B, 8'h80);
        peer.load(8'h5a, 1'b0);
        rd(B + 16'h0003, d);
        `CHK(d, 8'h00)
        rd(B, d);
        `CHK(d, 8'h81)
        repeat (20) begin
            @(posedge clock);
            #1 `CHK(so, 1'b0)
        end
        wait_idle();
        rd(B + 16'h0003, d);
        `CHK(d, 8'h5a)
        wr(B, 8'h00);
    endtask
    task automatic t_slave();
        wr(B + 16'h0001, 8'h07);
        wr(B, 8'he0);
        peer.load(8'hc3, 1'b0);
        wr(B + 16'h0002, 8'h69);
        rd(B, d);
        `CHK(d, 8'he0)
        `CHK(so_oe, 1'b0)
        @(posedge clock) ssn <= 1'b0;
        repeat (6) @(posedge clock);
        wr(B + 16'h0002, 8'h69);
        rd(B, d);
        `CHK(d, 8'he1)
        peer.frame();
        wait_idle();
        rd(B + 16'h0003, d);
        `CHK(d, 8'hc3)
        wr(B, 8'ha0);
        @(posedge clock) ssn <= 1'b1;
        repeat (6) @(posedge clock);
        rd(B + 16'h0003, d);
        rd(B, d);
        `CHK(d, 8'ha0)
        @(posedge clock) ssn <= 1'b0;
        repeat (6) @(posedge clock);
        peer.load(8'h3e, 1'b0);
        rd(B + 16'h0003, d);
        rd(B, d);
        `CHK(d, 8'ha1)
        peer.frame();
        wait_idle();
        rd(B + 16'h0003, d);
        `CHK(d, 8'h3e)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock   = 1'b0;
        rst_n   = 1'b0;
        addr    = 16'h0000;
        wr_data = 8'h00;
        wr_en   = 1'b0;
        rd_en   = 1'b0;
        ssn     = 1'b1;
        so_hold = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_master(8'ha5, 8'h3c, 1'b0);
        t_master(8'h96, 8'he1, 1'b1);
        t_disable();
        t_receive();
        t_slave();
        end_sim();
    end
endmodule
`default_nettype wire
